// file: rtl/ulpc_pkg.sv
// package: register map, field layout, codes and timing constants for the ulpi pin control block
package ulpc_pkg;

    // ************************************************************
    // register map (byte addresses on the axi4-lite slave)
    // ************************************************************
    localparam int         ADDR_W      = 5;
    localparam logic [4:0] OFF_CTRL    = 5'h00;
    localparam logic [4:0] OFF_STAT    = 5'h04;
    localparam logic [4:0] OFF_RXD     = 5'h08;
    localparam logic [4:0] OFF_RDD     = 5'h0c;
    localparam logic [4:0] OFF_LAST    = 5'h10;
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // ************************************************************
    // field layout and reset values
    // ************************************************************
    localparam int         CTRL_W      = 6;
    localparam logic [5:0] CTRL_RST    = 6'h00;
    localparam int         SB_DIR      = 0;
    localparam int         SB_NXT      = 1;
    localparam int         SB_FAULT    = 2;
    localparam int         SB_SEEN     = 3;
    localparam int         SB_RXP      = 4;
    localparam int         SB_ST       = 5;
    localparam int         RXD_BUSY    = 8;
    localparam int         RXC_VB_LSB  = 2;

    // ************************************************************
    // ulpi codes and timing
    // ************************************************************
    localparam logic [7:0] BUS_IDLE    = 8'h00;
    localparam logic [1:0] CMD_READ    = 2'h3;
    localparam logic [1:0] VBUS_OK     = 2'h3;
    localparam logic [1:0] VBUS_FAULT  = 2'h0;
    localparam logic [7:0] BLOCK_CYC   = 8'h10;

    typedef struct packed {
        logic low_power;
        logic host_mode;
        logic ignore_reset;
        logic external_vbus_drive;
        logic indicator_polarity_invert;
        logic ext_vbus_indicator_select;
    } ulpc_ctrl_t;

    typedef enum logic [2:0] {
        ST_BLOCK = 3'b000,
        ST_IDLE  = 3'b001,
        ST_TX    = 3'b010,
        ST_TURN  = 3'b011,
        ST_SEND  = 3'b100,
        ST_TDN   = 3'b101
    } ulpc_state_t;

    typedef enum logic [1:0] {
        K_RXCMD = 2'b00,
        K_RXD   = 2'b01,
        K_READ  = 2'b10
    } ulpc_kind_t;

    function automatic logic [7:0] rxcmd_byte(input logic fault);
        logic [7:0] b;
        b = 8'h00;
        b[RXC_VB_LSB+:2] = fault ? VBUS_FAULT : VBUS_OK;
        return b;
    endfunction

endpackage

// file: rtl/ulpc_sync.sv
// module: two-stage synchroniser for asynchronous pin inputs
`timescale 1ns/100ps
module ulpc_sync #(
    parameter int           W       = 2,
    parameter logic [W-1:0] RST_VAL = {W{1'b1}}
) (
    input  wire logic         clk,
    input  wire logic         rst_n,
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);

    logic [W-1:0] meta;

    // first stage feeds only the second stage
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            meta <= RST_VAL;
            q    <= RST_VAL;
        end else begin
            meta <= d;
            q    <= meta;
        end
    end

endmodule

// file: rtl/ulpc_pin_ctrl.sv
// module: ulpi transceiver pin control with axi4-lite control and status registers
`timescale 1ns/100ps
module ulpc_pin_ctrl (
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic [4:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [4:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    input  wire logic [7:0]  ulpi_data_in,
    output logic [7:0]       ulpi_data_out,
    output logic             ulpi_data_oe_n,
    output logic             ulpi_dir,
    output logic             ulpi_nxt,
    input  wire logic        ulpi_stp,
    input  wire logic        ulpi_stp_driven,
    output logic             ulpi_clk_out,
    input  wire logic        vbus_fault_in,
    input  wire logic        power_switch_out_n_in,
    output logic             power_switch_out_n_out,
    output logic             power_switch_out_n_oe_n
);

    // ************************************************************
    // pin synchronisers and reset
    // ************************************************************
    logic [1:0]          pin_s;
    ulpc_pkg::ulpc_ctrl_t ctrl;
    logic                ext_rst;
    logic                core_rst;
    logic                stp_eff;
    logic                fault_act;
    logic                fault_rep;
    logic                fault_pend;
    logic                fault_seen;

    ulpc_sync #(
        .W       (2),
        .RST_VAL (2'h3)
    ) u_sync (
        .clk   (clk),
        .rst_n (rst_n),
        .d     ({power_switch_out_n_in, vbus_fault_in}),
        .q     (pin_s)
    );

    // pin low resets the core registers, not the bus handshakes, unless software handed the pin to the switch
    assign ext_rst    = ~pin_s[1] & ~ctrl.ignore_reset;
    assign core_rst   = ~rst_n | ext_rst;
    assign stp_eff    = ulpi_stp | ~ulpi_stp_driven;
    assign fault_act  = ctrl.ext_vbus_indicator_select &
                        (pin_s[0] ^ ctrl.indicator_polarity_invert);
    assign fault_pend = fault_act != fault_rep;

    // ************************************************************
    // axi4-lite slave
    // ************************************************************
    logic [4:0]  aw_q;
    logic [31:0] w_q;
    logic [3:0]  ws_q;
    logic        wr_go;
    logic        wr_hit;
    logic        wr_ctrl;
    logic        wr_stat;
    logic        wr_rxd;
    logic        wr_rdd;
    logic        rd_hit;
    logic [31:0] rd_word;
    logic [31:0] stat_word;

    assign wr_go   = ~s_axi_awready & ~s_axi_wready & ~s_axi_bvalid;
    assign wr_ctrl = wr_go & (aw_q == ulpc_pkg::OFF_CTRL) & ws_q[0];
    assign wr_stat = wr_go & (aw_q == ulpc_pkg::OFF_STAT) & ws_q[0];
    assign wr_rxd  = wr_go & (aw_q == ulpc_pkg::OFF_RXD) & ws_q[0];
    assign wr_rdd  = wr_go & (aw_q == ulpc_pkg::OFF_RDD) & ws_q[0];
    assign wr_hit  = (aw_q == ulpc_pkg::OFF_CTRL) | (aw_q == ulpc_pkg::OFF_STAT) |
                     (aw_q == ulpc_pkg::OFF_RXD) | (aw_q == ulpc_pkg::OFF_RDD);

    // bus handshakes use the bus reset only, so a pin reset never strands a transfer
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= ulpc_pkg::RESP_OKAY;
            aw_q          <= 5'h00;
            w_q           <= 32'h0000_0000;
            ws_q          <= 4'h0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                s_axi_awready <= 1'b0;
                aw_q          <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                s_axi_wready <= 1'b0;
                w_q          <= s_axi_wdata;
                ws_q         <= s_axi_wstrb;
            end
            if (wr_go) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= wr_hit ? ulpc_pkg::RESP_OKAY : ulpc_pkg::RESP_SLVERR;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid  <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready  <= 1'b1;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0000_0000;
            s_axi_rresp   <= ulpc_pkg::RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b1;
            s_axi_rdata   <= rd_word;
            s_axi_rresp   <= rd_hit ? ulpc_pkg::RESP_OKAY : ulpc_pkg::RESP_SLVERR;
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid  <= 1'b0;
            s_axi_arready <= 1'b1;
        end
    end

    // ************************************************************
    // registers
    // ************************************************************
    ulpc_pkg::ulpc_state_t state;
    ulpc_pkg::ulpc_state_t next_state;
    ulpc_pkg::ulpc_kind_t  kind;
    ulpc_pkg::ulpc_kind_t  next_kind;
    logic [7:0]  rx_byte;
    logic        rx_pend;
    logic [7:0]  rd_byte;
    logic [7:0]  cmd;
    logic [7:0]  last_byte;
    logic [7:0]  byte_cnt;
    logic        sending;

    assign sending = (state == ulpc_pkg::ST_TURN) && (next_state == ulpc_pkg::ST_SEND);

    always_ff @(posedge clk) begin
        if (core_rst) begin
            ctrl    <= ulpc_pkg::ulpc_ctrl_t'(ulpc_pkg::CTRL_RST);
            rd_byte <= 8'h00;
        end else begin
            if (wr_ctrl) begin
                ctrl <= ulpc_pkg::ulpc_ctrl_t'(w_q[ulpc_pkg::CTRL_W-1:0]);
            end
            if (wr_rdd) begin
                rd_byte <= w_q[7:0];
            end
        end
    end

    // a new fault level wins over a software clear in the same cycle
    always_ff @(posedge clk) begin
        if (core_rst) begin
            fault_seen <= 1'b0;
            fault_rep  <= 1'b0;
            rx_pend    <= 1'b0;
            rx_byte    <= 8'h00;
        end else begin
            fault_seen <= fault_act | (fault_seen & ~(wr_stat & w_q[ulpc_pkg::SB_SEEN]));
            if (sending && kind == ulpc_pkg::K_RXCMD) begin
                fault_rep <= fault_act;
            end
            if (wr_rxd && !rx_pend) begin
                rx_pend <= 1'b1;
                rx_byte <= w_q[7:0];
            end else if (sending && kind == ulpc_pkg::K_RXD) begin
                rx_pend <= 1'b0;
            end
        end
    end

    always_comb begin
        stat_word = 32'h0000_0000;
        stat_word[ulpc_pkg::SB_DIR]     = ulpi_dir;
        stat_word[ulpc_pkg::SB_NXT]     = ulpi_nxt;
        stat_word[ulpc_pkg::SB_FAULT]   = fault_act;
        stat_word[ulpc_pkg::SB_SEEN]    = fault_seen;
        stat_word[ulpc_pkg::SB_RXP]     = rx_pend;
        stat_word[ulpc_pkg::SB_ST+:3]   = state;
    end

    always_comb begin
        rd_hit  = 1'b1;
        rd_word = 32'h0000_0000;
        case (s_axi_araddr)
            ulpc_pkg::OFF_CTRL: rd_word = 32'(ctrl);
            ulpc_pkg::OFF_STAT: rd_word = stat_word;
            ulpc_pkg::OFF_RXD:  rd_word = {23'h0, rx_pend, rx_byte};
            ulpc_pkg::OFF_RDD:  rd_word = {24'h0, rd_byte};
            ulpc_pkg::OFF_LAST: rd_word = {8'h00, byte_cnt, last_byte, cmd};
            default:            rd_hit  = 1'b0;
        endcase
    end

    // ************************************************************
    // ulpi bus sequencer
    // ************************************************************
    logic [7:0] blk_cnt;
    logic [7:0] next_cnt;
    logic       next_dir;
    logic       next_nxt;
    logic [7:0] next_dout;
    logic       next_oe_n;
    logic       is_read;

    assign is_read = cmd[7:6] == ulpc_pkg::CMD_READ;

    always_comb begin
        next_state = state;
        next_kind  = kind;
        next_cnt   = blk_cnt;
        next_dir   = ulpi_dir;
        next_nxt   = 1'b0;
        next_dout  = ulpc_pkg::BUS_IDLE;
        next_oe_n  = 1'b1;
        unique case (state)
            ulpc_pkg::ST_BLOCK: begin
                next_dir = 1'b1;
                if (blk_cnt != 8'h00) begin
                    next_cnt = blk_cnt - 8'h01;
                end else if (!ctrl.low_power) begin
                    next_dir   = 1'b0;
                    next_state = ulpc_pkg::ST_TDN;
                end
            end
            ulpc_pkg::ST_IDLE: begin
                next_dir = 1'b0;
                if (ctrl.low_power) begin
                    next_dir   = 1'b1;
                    next_state = ulpc_pkg::ST_BLOCK;
                end else if (fault_pend) begin
                    next_dir   = 1'b1;
                    next_kind  = ulpc_pkg::K_RXCMD;
                    next_state = ulpc_pkg::ST_TURN;
                end else if (rx_pend) begin
                    next_dir   = 1'b1;
                    next_kind  = ulpc_pkg::K_RXD;
                    next_state = ulpc_pkg::ST_TURN;
                end else if (ulpi_data_in != ulpc_pkg::BUS_IDLE) begin
                    next_nxt   = 1'b1;
                    next_state = ulpc_pkg::ST_TX;
                end
            end
            ulpc_pkg::ST_TX: begin
                if (stp_eff) begin
                    next_state = ulpc_pkg::ST_IDLE;
                end else if (is_read && ulpi_nxt) begin
                    next_dir   = 1'b1;
                    next_kind  = ulpc_pkg::K_READ;
                    next_state = ulpc_pkg::ST_TURN;
                end else begin
                    next_nxt = 1'b1;
                end
            end
            ulpc_pkg::ST_TURN: begin
                if (stp_eff) begin
                    next_dir   = 1'b0;
                    next_state = ulpc_pkg::ST_TDN;
                end else begin
                    next_oe_n  = 1'b0;
                    next_nxt   = kind == ulpc_pkg::K_RXD;
                    next_dout  = kind == ulpc_pkg::K_RXD ? rx_byte :
                                 kind == ulpc_pkg::K_READ ? rd_byte : ulpc_pkg::rxcmd_byte(fault_act);
                    next_state = ulpc_pkg::ST_SEND;
                end
            end
            ulpc_pkg::ST_SEND: begin
                next_dir   = 1'b0;
                next_state = ulpc_pkg::ST_TDN;
            end
            ulpc_pkg::ST_TDN: begin
                next_state = ulpc_pkg::ST_IDLE;
            end
            default: begin
                next_state = ulpc_pkg::ST_IDLE;
            end
        endcase
    end

    // reset holds dir high to fence the link off the bus
    always_ff @(posedge clk) begin
        if (core_rst) begin
            state          <= ulpc_pkg::ST_BLOCK;
            kind           <= ulpc_pkg::K_RXCMD;
            blk_cnt        <= ulpc_pkg::BLOCK_CYC;
            ulpi_dir       <= 1'b1;
            ulpi_nxt       <= 1'b0;
            ulpi_data_out  <= ulpc_pkg::BUS_IDLE;
            ulpi_data_oe_n <= 1'b1;
        end else begin
            state          <= next_state;
            kind           <= next_kind;
            blk_cnt        <= next_cnt;
            ulpi_dir       <= next_dir;
            ulpi_nxt       <= next_nxt;
            ulpi_data_out  <= next_dout;
            ulpi_data_oe_n <= next_oe_n;
        end
    end

    always_ff @(posedge clk) begin
        if (core_rst) begin
            cmd       <= 8'h00;
            last_byte <= 8'h00;
            byte_cnt  <= 8'h00;
        end else if (state == ulpc_pkg::ST_IDLE && next_state == ulpc_pkg::ST_TX) begin
            cmd      <= ulpi_data_in;
            byte_cnt <= 8'h00;
        end else if (state == ulpc_pkg::ST_TX && ulpi_nxt && !stp_eff) begin
            last_byte <= ulpi_data_in;
            byte_cnt  <= byte_cnt + 8'h01;
        end
    end

    // ************************************************************
    // interface clock and power switch pin
    // ************************************************************
    // clk is 20 mhz, so the bus clock is a half-rate stand-in for the nominal 60 mhz
    always_ff @(posedge clk) begin
        if (core_rst) begin
            ulpi_clk_out            <= 1'b0;
            power_switch_out_n_out  <= 1'b0;
            power_switch_out_n_oe_n <= 1'b1;
        end else begin
            ulpi_clk_out            <= ~ulpi_clk_out;
            power_switch_out_n_out  <= 1'b0;
            // only drive once the pin no longer doubles as our own reset
            power_switch_out_n_oe_n <= ~(ctrl.external_vbus_drive & ctrl.host_mode &
                                         ctrl.ignore_reset);
        end
    end

    // ************************************************************
    // assertions
    // ************************************************************
    property p_abort;
        @(posedge clk) disable iff (core_rst)
        (stp_eff && (state == ulpc_pkg::ST_TURN || state == ulpc_pkg::ST_SEND)) |=> !ulpi_dir;
    endproperty
    a_abort: assert property (p_abort) else $error("dir not dropped after stp abort");

    property p_turn;
        @(posedge clk) disable iff (core_rst)
        $changed(ulpi_dir) |-> ulpi_data_oe_n;
    endproperty
    a_turn: assert property (p_turn) else $error("data driven in turnaround cycle");

    property p_nxt_data;
        @(posedge clk) disable iff (core_rst)
        (ulpi_dir && ulpi_nxt) |-> (kind == ulpc_pkg::K_RXD && !ulpi_data_oe_n);
    endproperty
    a_nxt_data: assert property (p_nxt_data) else $error("nxt high on non data byte");

    property p_idle_dir;
        @(posedge clk) disable iff (core_rst)
        (state == ulpc_pkg::ST_IDLE) |-> !ulpi_dir;
    endproperty
    a_idle_dir: assert property (p_idle_dir) else $error("dir high while idle");

    property p_nxt_req;
        @(posedge clk) disable iff (core_rst)
        (state == ulpc_pkg::ST_IDLE && !ctrl.low_power && !fault_pend && !rx_pend &&
         ulpi_data_in != ulpc_pkg::BUS_IDLE) |=> (ulpi_nxt && !ulpi_dir);
    endproperty
    a_nxt_req: assert property (p_nxt_req) else $error("transmit command not acknowledged");

    property p_psw;
        @(posedge clk) disable iff (core_rst)
        (ctrl.external_vbus_drive && ctrl.host_mode && ctrl.ignore_reset) |=>
            (!power_switch_out_n_oe_n && !power_switch_out_n_out);
    endproperty
    a_psw: assert property (p_psw) else $error("power switch not pulled low");

    property p_fault;
        @(posedge clk) disable iff (core_rst)
        (fault_pend && state == ulpc_pkg::ST_IDLE && !ctrl.low_power) |=>
            (state == ulpc_pkg::ST_TURN && kind == ulpc_pkg::K_RXCMD && ulpi_dir) ##1
            (stp_eff || $past(stp_eff) || (!ulpi_nxt && !ulpi_data_oe_n));
    endproperty
    a_fault: assert property (p_fault) else $error("fault change not reported");

    property p_vbus;
        @(posedge clk) disable iff (core_rst)
        (state == ulpc_pkg::ST_SEND && kind == ulpc_pkg::K_RXCMD) |->
            ulpi_data_out[ulpc_pkg::RXC_VB_LSB+:2] ==
            (fault_rep ? ulpc_pkg::VBUS_FAULT : ulpc_pkg::VBUS_OK);
    endproperty
    a_vbus: assert property (p_vbus) else $error("rxcmd vbus state wrong");

    property p_ext_rst;
        @(posedge clk) disable iff (!rst_n)
        ext_rst |=> (state == ulpc_pkg::ST_BLOCK && ulpi_dir && !ulpi_nxt);
    endproperty
    a_ext_rst: assert property (p_ext_rst) else $error("reset pin ignored");

    property p_block;
        @(posedge clk) disable iff (core_rst)
        (state == ulpc_pkg::ST_BLOCK && blk_cnt != 8'h00) |=> (state == ulpc_pkg::ST_BLOCK && ulpi_dir);
    endproperty
    a_block: assert property (p_block) else $error("block released early");

    property p_clk;
        @(posedge clk) disable iff (core_rst)
        ulpi_clk_out |=> !ulpi_clk_out ##1 ulpi_clk_out;
    endproperty
    a_clk: assert property (p_clk) else $error("interface clock not toggling");

    property p_stp_pull;
        @(posedge clk) disable iff (core_rst)
        (!ulpi_stp_driven && state == ulpc_pkg::ST_TX) |=> (state == ulpc_pkg::ST_IDLE && !ulpi_nxt);
    endproperty
    a_stp_pull: assert property (p_stp_pull) else $error("undriven stp not seen as stop");

endmodule

// file: testbench/ulpc_link_model.sv
// link partner model: drives the link side and resolves the shared data wire
`timescale 1ns/100ps
module ulpc_link_model (
    input  wire logic       clk,
    input  wire logic       ulpi_dir,
    input  wire logic [7:0] ulpi_data_out,
    input  wire logic       ulpi_data_oe_n,
    input  wire logic [7:0] tx_byte,
    input  wire logic       tx_stp,
    output logic      [7:0] ulpi_data_in,
    output logic            ulpi_stp
);
    logic [7:0] last = 8'h5a;
    // released bus flips each cycle, never a stale byte
    always @(posedge clk) last <= ulpi_data_in;
    // synchronous mode only: the low power mode that the test selects just sees the released bus
    assign ulpi_data_in = !ulpi_data_oe_n ? ulpi_data_out : (ulpi_dir ? ~last : tx_byte);
    assign ulpi_stp = tx_stp;
endmodule

// file: testbench/test_ulpi_phy_pin_control.sv
// testbench: register and ulpi link checks of the pin control block
`timescale 1ns/100ps
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin n_fail++; $display("wrong value %0t %h %h", $time, g, e); end end
module test_ulpi_phy_pin_control;
    logic clk = 0, rst_n = 0, ulpi_stp_driven = 1, vbus_fault_in = 0, power_switch_out_n_in = 1, tx_stp = 0;
    logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, ulpi_dir, ulpi_nxt, ulpi_stp;
    logic ulpi_data_oe_n, ulpi_clk_out, power_switch_out_n_out, power_switch_out_n_oe_n;
    logic [4:0] s_axi_awaddr = 0, s_axi_araddr = 0;
    logic [31:0] s_axi_wdata = 0, s_axi_rdata, rd;
    logic [3:0] s_axi_wstrb = 4'hf;
    logic [1:0] s_axi_bresp, s_axi_rresp, rs;
    logic [7:0] ulpi_data_in, ulpi_data_out, tx_byte = 0;
    int n_fail = 0, checks = 0;
    always #25 clk = ~clk;
    ulpc_pin_ctrl dut_u (.*);
    ulpc_link_model link_u (.*);
    // ready lines stay high between transfers; only the watchdog ends a wait
    task automatic wr(input logic [4:0] a, input logic [31:0] d);
        {s_axi_awaddr, s_axi_wdata} <= {a, d};
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
        do begin
            @(posedge clk);
            if (s_axi_awready) s_axi_awvalid <= 0;
            if (s_axi_wready) s_axi_wvalid <= 0;
        end while (!s_axi_bvalid);
        rs = s_axi_bresp;
    endtask
    task automatic rdw(input logic [4:0] a);
        {s_axi_araddr, s_axi_arvalid, s_axi_rready} <= {a, 2'h3};
        do begin
            @(posedge clk);
            if (s_axi_arready) s_axi_arvalid <= 0;
        end while (!s_axi_rvalid);
        {rd, rs} = {s_axi_rdata, s_axi_rresp};
    endtask
    // sampled just after the edge: the value of the cycle before
    task automatic wt(input logic s, input logic v);
        do begin @(posedge clk); end while ((s ? ulpi_nxt : ulpi_dir) !== v);
    endtask
    task automatic rx(input logic [7:0] e, input logic x);
        wt(0, 1);
        `CHK(ulpi_data_oe_n, 1'h1)
        @(posedge clk);
        `CHK(ulpi_data_in, e)
        `CHK(ulpi_nxt, x)
        wt(0, 0);
    endtask
    task automatic complete_run;
        $display("checks %0d mismatches %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    // ********
    // tests
    // ********
    initial begin
        repeat (12) @(posedge clk);
        `CHK(ulpi_dir, 1'h1)
        rst_n <= 1;
        wt(0, 0);
        `CHK(ulpi_nxt, 1'h0)
        rdw(ulpc_pkg::OFF_CTRL);
        `CHK(rd, 32'h0)
        rdw(5'h14);
        `CHK({rs, rd}, {ulpc_pkg::RESP_SLVERR, 32'h0})
        wr(5'h14, 32'h3f);
        `CHK(rs, ulpc_pkg::RESP_SLVERR)
        $display("test registers done");
        tx_byte <= 8'h41;
        wt(1, 1);
        tx_byte <= 8'h5a;
        @(posedge clk);
        {tx_byte, tx_stp} <= 9'h1;
        @(posedge clk);
        tx_stp <= 0;
        rdw(ulpc_pkg::OFF_LAST);
        `CHK(rd, 32'h25a41)
        // undriven stp mid-packet must end it through the pull-up
        tx_byte <= 8'h42;
        wt(1, 1);
        {tx_byte, ulpi_stp_driven} <= 9'h0;
        @(posedge clk);
        ulpi_stp_driven <= 1;
        @(posedge clk);
        `CHK(ulpi_nxt, 1'h0)
        rdw(ulpc_pkg::OFF_LAST);
        `CHK(rd, 32'h14242)
        wr(ulpc_pkg::OFF_RDD, 32'ha7);
        tx_byte <= 8'hc5;
        wt(1, 1);
        tx_byte <= 0;
        rx(8'ha7, 0);
        $display("test link done");
        for (int i = 0; i < 2; i++) begin
            wr(ulpc_pkg::OFF_CTRL, 32'h0);
            vbus_fault_in <= i[0];
            repeat (3) @(posedge clk);
            wr(ulpc_pkg::OFF_CTRL, {30'h0, i[0], 1'h1});
            vbus_fault_in <= !i[0];
            rx(8'h00, 0);
            vbus_fault_in <= i[0];
            rx(8'h0c, 0);
        end
        $display("test fault done");
        wr(ulpc_pkg::OFF_STAT, 32'h8);
        wr(ulpc_pkg::OFF_CTRL, 32'h20);
        wt(0, 1);
        rdw(ulpc_pkg::OFF_STAT);
        `CHK(rd, 32'h1)
        wr(ulpc_pkg::OFF_CTRL, 32'h0);
        wt(0, 0);
        $display("test low power done");
        // stp left undriven from before the turnaround, so the first try is aborted
        ulpi_stp_driven <= 0;
        wr(ulpc_pkg::OFF_RXD, 32'h33);
        wt(0, 1);
        ulpi_stp_driven <= 1;
        @(posedge clk);
        `CHK(ulpi_dir, 1'h0)
        rx(8'h33, 1);
        $display("test abort done");
        wr(ulpc_pkg::OFF_CTRL, 32'h1c);
        @(posedge clk);
        `CHK(power_switch_out_n_oe_n, 1'h0)
        `CHK(power_switch_out_n_out, 1'h0)
        rd[0] = ulpi_clk_out;
        @(posedge clk);
        `CHK(ulpi_clk_out, ~rd[0])
        wr(ulpc_pkg::OFF_CTRL, 32'h10);
        @(posedge clk);
        `CHK(power_switch_out_n_oe_n, 1'h1)
        power_switch_out_n_in <= 0;
        repeat (4) @(posedge clk);
        `CHK(ulpi_dir, 1'h1)
        power_switch_out_n_in <= 1;
        rdw(ulpc_pkg::OFF_CTRL);
        `CHK(rd, 32'h0)
        $display("test power done");
        complete_run;
    end
    initial begin
        #200000;
        n_fail++;
        complete_run;
    end
endmodule
